// file: semh_ctrl.sv
// controller driving one port's semaphore pins of a dual-port memory
// Contract
// - write zero requests, write one releases
// - semaphore select low, then normal memory signalling
// - deassert select or enable between polling reads
// - write zero then read back to acquire
// - write one to every token at start
`timescale 1ns/100ps
`include "semh_regs.svh"
module semh_ctrl
    import semh_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    input wire semh_req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output semh_rsp_t rsp_o,
    output semh_pins_t pins_o,
    input wire logic [`SEMH_DATA_W-1:0] dq_i
);

    semh_state_t state_r;
    semh_op_t op_r;
    logic [`SEMH_IDX_W-1:0] idx_r;
    logic wr_val_r;
    logic rd_done_r;
    logic [7:0] cnt_r;
    logic ready_r;
    logic done_r;
    semh_rsp_t rsp_r;
    semh_pins_t pins_r;
    semh_pins_t pins_nxt;
    logic [`SEMH_DATA_W-1:0] dq_sync;

    // cycles minus one for a least time, never below one cycle
    function automatic logic [7:0] cyc_of(input int ns);
        int c;
        c = (ns + `SEMH_CLK_NS - 1) / `SEMH_CLK_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return 8'(c - 1);
    endfunction : cyc_of

    // read wait also covers the pin register and the synchroniser
    function automatic logic [7:0] rd_cnt();
        return 8'(cyc_of(`SEMH_RD_NS) + `SEMH_SYNC_LAT);
    endfunction : rd_cnt

    semh_sync u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i(dq_i),
        .q_o(dq_sync)
    );

    // sequencer; reset starts the release sweep over all tokens
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            state_r <= ST_WSET;
            op_r <= OP_INIT;
            idx_r <= 3'h0;
            wr_val_r <= `SEMH_FREE;
            rd_done_r <= 1'b0;
            cnt_r <= cyc_of(`SEMH_SETUP_NS);
            ready_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (state_r != ST_IDLE && state_r != ST_DONE && cnt_r != 8'h00)
            begin
                cnt_r <= cnt_r - 8'h01;
            end
            else
            begin
                unique case (state_r)
                    ST_IDLE:
                    begin
                        if (req_valid_i)
                        begin
                            op_r <= req_i.op;
                            idx_r <= req_i.idx;
                            rd_done_r <= 1'b0;
                            unique case (req_i.op)
                                OP_TRY, OP_WAIT:
                                begin
                                    wr_val_r <= `SEMH_CLAIM;
                                    state_r <= ST_WSET;
                                    cnt_r <= cyc_of(`SEMH_SETUP_NS);
                                    ready_r <= 1'b0;
                                end
                                OP_REL:
                                begin
                                    wr_val_r <= `SEMH_FREE;
                                    state_r <= ST_WSET;
                                    cnt_r <= cyc_of(`SEMH_SETUP_NS);
                                    ready_r <= 1'b0;
                                end
                                OP_INIT:
                                begin
                                    idx_r <= 3'h0;
                                    wr_val_r <= `SEMH_FREE;
                                    state_r <= ST_WSET;
                                    cnt_r <= cyc_of(`SEMH_SETUP_NS);
                                    ready_r <= 1'b0;
                                end
                                OP_PEEK:
                                begin
                                    state_r <= ST_RD;
                                    cnt_r <= rd_cnt();
                                    ready_r <= 1'b0;
                                end
                                default:
                                begin
                                    state_r <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                    ST_WSET:
                    begin
                        state_r <= ST_WPUL;
                        cnt_r <= cyc_of(`SEMH_WR_NS);
                    end
                    ST_WPUL:
                    begin
                        state_r <= ST_WHLD;
                        cnt_r <= cyc_of(`SEMH_HOLD_NS);
                    end
                    ST_WHLD:
                    begin
                        state_r <= ST_GAP;
                        cnt_r <= cyc_of(`SEMH_GAP_NS);
                    end
                    ST_RD:
                    begin
                        rd_done_r <= 1'b1;
                        state_r <= ST_GAP;
                        cnt_r <= cyc_of(`SEMH_GAP_NS);
                    end
                    ST_GAP:
                    begin
                        if (op_r == OP_INIT && idx_r != `SEMH_LAST_IDX)
                        begin
                            idx_r <= idx_r + 3'h1;
                            state_r <= ST_WSET;
                            cnt_r <= cyc_of(`SEMH_SETUP_NS);
                        end
                        else if ((op_r == OP_TRY || op_r == OP_WAIT) &&
                                 !rd_done_r)
                        begin
                            state_r <= ST_RD;
                            cnt_r <= rd_cnt();
                        end
                        else if (op_r == OP_WAIT && !rsp_r.granted)
                        begin
                            // the request stays latched; poll until it wins
                            state_r <= ST_RD;
                            cnt_r <= rd_cnt();
                        end
                        else
                        begin
                            state_r <= ST_DONE;
                            done_r <= 1'b1;
                        end
                    end
                    ST_DONE:
                    begin
                        state_r <= ST_IDLE;
                        ready_r <= 1'b1;
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                        ready_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // result; the flag sits on every bit so bit zero speaks for all
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            rsp_r <= '0;
        end
        else if (state_r == ST_RD && cnt_r == 8'h00)
        begin
            rsp_r.granted <= ~dq_sync[0];
            rsp_r.word <= dq_sync;
        end
    end

    // pin image; array select is never asserted by this port
    always_comb
    begin
        pins_nxt = '0;
        pins_nxt.sem_n = 1'b1;
        pins_nxt.ce_n = 1'b1;
        pins_nxt.oe_n = 1'b1;
        pins_nxt.rw_n = 1'b1;
        pins_nxt.dq_oe_n = 1'b1;
        unique case (state_r)
            ST_WSET, ST_WPUL, ST_WHLD:
            begin
                pins_nxt.sem_n = 1'b0;
                pins_nxt.addr = {10'h000, idx_r};
                pins_nxt.dq = {15'h0000, wr_val_r};
                pins_nxt.dq_oe_n = 1'b0;
                pins_nxt.rw_n = (state_r != ST_WPUL);
            end
            ST_RD:
            begin
                pins_nxt.sem_n = 1'b0;
                pins_nxt.oe_n = 1'b0;
                pins_nxt.addr = {10'h000, idx_r};
            end
            default:
            begin
                pins_nxt.sem_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            // one whole-word write, so no select or strobe glitches low
            pins_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0000, 16'h0000, 1'b1};
        end
        else
        begin
            pins_r <= pins_nxt;
        end
    end

    assign req_ready_o = ready_r;
    assign done_o = done_r;
    assign rsp_o = rsp_r;
    assign pins_o = pins_r;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_array_idle: assert property (pins_o.ce_n)
        else $error("array select asserted");
    chk_poll_gap: assert property
        ($rose(pins_o.oe_n) |-> pins_o.oe_n [*2])
        else $error("enable not high two cycles between reads");
    chk_try_read_back: assert property
        (done_o && (op_r == OP_TRY || op_r == OP_WAIT) |-> rd_done_r)
        else $error("claim finished without read back");
    chk_grant_flag: assert property
        ($changed(rsp_o) |-> !$past(pins_o.oe_n))
        else $error("result changed outside a read");
    chk_wait_wins: assert property (done_o && op_r == OP_WAIT |->
        rsp_o.granted)
        else $error("waiting claim ended without token");
    chk_upper_addr: assert property
        (!pins_o.sem_n |-> pins_o.addr[12:3] == 10'h000)
        else $error("upper address lines not zero");
    chk_data_bit0: assert property
        (!pins_o.dq_oe_n |-> pins_o.dq[15:1] == 15'h0000)
        else $error("upper data bits driven nonzero");
    chk_read_no_drive: assert property
        (!pins_o.oe_n |-> pins_o.dq_oe_n && pins_o.rw_n && !pins_o.sem_n)
        else $error("bus driven during read");
    chk_wr_pulse: assert property
        ($fell(pins_o.rw_n) |-> !pins_o.sem_n [*4] ##1 pins_o.rw_n)
        else $error("write pulse not four cycles");
    chk_wr_width: assert property
        ($fell(pins_o.rw_n) |-> !pins_o.rw_n [*4])
        else $error("write pulse too short");
    chk_init_free: assert property
        (op_r == OP_INIT && !pins_o.dq_oe_n |-> pins_o.dq[0])
        else $error("init wrote a claim");
    chk_release_one: assert property
        (op_r == OP_REL && !pins_o.rw_n |-> pins_o.dq[0])
        else $error("release did not write one");

    cov_init_done: cover property (op_r == OP_INIT && done_o);
    cov_grant: cover property (done_o && op_r == OP_TRY && rsp_o.granted);
    cov_fail: cover property (done_o && op_r == OP_TRY && !rsp_o.granted);
    cov_repoll: cover property
        (op_r == OP_WAIT && rd_done_r && $fell(pins_o.oe_n));

endmodule : semh_ctrl

// file: semh_dev.sv
// behavioural model of the device's token latches facing both ports
`timescale 1ns/100ps
`include "semh_regs.svh"
module semh_dev
    import semh_pkg::*;
(
    input wire semh_pins_t l_pins_i,
    input wire semh_pins_t r_pins_i,
    output logic [`SEMH_DATA_W-1:0] l_dq_o,
    output logic [`SEMH_DATA_W-1:0] r_dq_o
);
    // holder per token: 0 free, 1 left, 2 right; no busy, no wait output
    logic [1:0] owner [8];
    logic req_n [2][8];
    logic lat [2];
    logic l_rd_n;
    logic r_rd_n;

    // no defined power-up state: left holds, right already pending
    initial
    begin
        foreach (owner[i])
        begin
            owner[i] = 2'h1;
            req_n[0][i] = 1'b0;
            req_n[1][i] = 1'b0;
        end
        lat[0] = 1'b0;
        lat[1] = 1'b0;
    end

    // one process order decides a true tie, an earlier write simply wins
    function automatic void token_wr(input int s, input logic [2:0] i,
        input logic d);
        req_n[s][i] = d;
        if (owner[i] == 2'h0 && !d)
            owner[i] = 2'(s + 1);
        else if (owner[i] == 2'(s + 1) && d)
            owner[i] = req_n[1 - s][i] ? 2'h0 : 2'(2 - s);
    endfunction : token_wr

    function automatic logic flag(input int s, input logic [2:0] i);
        return owner[i] != 2'(s + 1);
    endfunction : flag

    // writes land as the strobe ends; the array select plays no part
    always @(posedge l_pins_i.rw_n)
        if (!l_pins_i.sem_n)
            token_wr(0, l_pins_i.addr[2:0], l_pins_i.dq[0]);
    always @(posedge r_pins_i.rw_n)
        if (!r_pins_i.sem_n)
            token_wr(1, r_pins_i.addr[2:0], r_pins_i.dq[0]);
    assign l_rd_n = l_pins_i.sem_n | l_pins_i.oe_n;
    assign r_rd_n = r_pins_i.sem_n | r_pins_i.oe_n;
    // captured once per select, so a poll that never deselects goes stale
    always @(negedge l_rd_n)
        lat[0] = flag(0, l_pins_i.addr[2:0]);
    always @(negedge r_rd_n)
        lat[1] = flag(1, r_pins_i.addr[2:0]);
    // a deselected port floats: show the inverse rather than stale data
    assign l_dq_o = {`SEMH_DATA_W{lat[0] ^ l_rd_n}};
    assign r_dq_o = {`SEMH_DATA_W{lat[1] ^ r_rd_n}};
endmodule : semh_dev

// file: semh_pkg.sv
// types shared by the semaphore port controller
`include "semh_regs.svh"
package semh_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_WSET = 4'h1,
        ST_WPUL = 4'h2,
        ST_WHLD = 4'h3,
        ST_RD   = 4'h4,
        ST_GAP  = 4'h5,
        ST_DONE = 4'h6
    } semh_state_t;

    typedef enum logic [2:0] {
        OP_TRY  = 3'h0,
        OP_WAIT = 3'h1,
        OP_REL  = 3'h2,
        OP_PEEK = 3'h3,
        OP_INIT = 3'h4
    } semh_op_t;

    typedef struct packed {
        semh_op_t op;
        logic [`SEMH_IDX_W-1:0] idx;
    } semh_req_t;

    typedef struct packed {
        logic granted;
        logic [`SEMH_DATA_W-1:0] word;
    } semh_rsp_t;

    typedef struct packed {
        logic sem_n;
        logic ce_n;
        logic oe_n;
        logic rw_n;
        logic [`SEMH_ADDR_W-1:0] addr;
        logic [`SEMH_DATA_W-1:0] dq;
        logic dq_oe_n;
    } semh_pins_t;

endpackage : semh_pkg

// file: semh_regs.svh
// constants for the semaphore port controller: widths, values and timing
`ifndef SEMH_REGS_SVH
`define SEMH_REGS_SVH
`define SEMH_ADDR_W 13
`define SEMH_DATA_W 16
`define SEMH_IDX_W 3
`define SEMH_LAST_IDX 3'h7
`define SEMH_FREE 1'b1
`define SEMH_CLAIM 1'b0
`define SEMH_CLK_NS 10
`define SEMH_SETUP_NS 10
`define SEMH_WR_NS 40
`define SEMH_HOLD_NS 10
`define SEMH_RD_NS 60
`define SEMH_GAP_NS 20
`define SEMH_SYNC_LAT 8'h03
`endif

// file: semh_sync.sv
// two-flop synchroniser for the data bus read back from the port
`timescale 1ns/100ps
`include "semh_regs.svh"
module semh_sync
    import semh_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [`SEMH_DATA_W-1:0] d_i,
    output logic [`SEMH_DATA_W-1:0] q_o
);

    logic [`SEMH_DATA_W-1:0] meta_r;
    logic [`SEMH_DATA_W-1:0] q_r;

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= 16'h0000;
            q_r <= 16'h0000;
        end
        else
        begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule : semh_sync

// file: tb_semh_ctrl.sv
// self-checking bench: controller on the left port, tasks on the right
`timescale 1ns/100ps
`include "semh_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_semh_ctrl
    import semh_pkg::*;
;
    localparam semh_pins_t r_idle = '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0,
        16'h0, 1'b1};
    // cycles for one write: setup, strobe, hold and the gap after it
    localparam int wr_cyc = (`SEMH_SETUP_NS + `SEMH_WR_NS + `SEMH_HOLD_NS +
        `SEMH_GAP_NS) / `SEMH_CLK_NS;
    logic mclk_i;
    logic rstn_i;
    logic req_valid_i;
    semh_req_t req_i;
    logic req_ready_o;
    logic done_o;
    semh_rsp_t rsp_o;
    semh_pins_t pins_o;
    logic [`SEMH_DATA_W-1:0] l_dq;
    logic [`SEMH_DATA_W-1:0] r_dq;
    semh_pins_t rp;
    int error_cnt = 0;
    int num_checks = 0;
    int c;

    semh_ctrl u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .rsp_o(rsp_o), .pins_o(pins_o), .dq_i(l_dq));
    semh_dev u_dev (.l_pins_i(pins_o), .r_pins_i(rp), .l_dq_o(l_dq),
        .r_dq_o(r_dq));

    always #5 mclk_i = ~mclk_i;

    always @(negedge mclk_i)
    begin
        if (rstn_i === 1'b1)
        begin
            `CHK(pins_o.ce_n, 1'b1)
            `CHK(pins_o.addr[12:3], 10'h0)
            `CHK(pins_o.dq[15:1] & {15{~pins_o.dq_oe_n}}, 15'h0)
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    task automatic wait_done(input int lim);
        c = 0;
        while (done_o !== 1'b1 && c < lim)
        begin
            tick(1);
            c++;
        end
        `CHK(done_o, 1'b1)
    endtask : wait_done

    task automatic do_op(input semh_op_t op, input logic [2:0] i,
        input int lim);
        c = 0;
        while (req_ready_o !== 1'b1 && c < 300)
        begin
            tick(1);
            c++;
        end
        `CHK(req_ready_o, 1'b1)
        req_i = '{op, i};
        req_valid_i = 1'b1;
        tick(1);
        req_valid_i = 1'b0;
        wait_done(lim);
    endtask : do_op

    // other side's writes carry junk on high address and data bits
    task automatic r_wr(input logic [2:0] i, input logic d);
        rp = '{1'b0, 1'b1, 1'b1, 1'b0, {10'h2aa, i}, {15'h5555, d}, 1'b0};
        tick(4);
        rp.rw_n = 1'b1;
        tick(1);
        rp = r_idle;
        tick(2);
    endtask : r_wr

    task automatic r_rd(input logic [2:0] i, input logic f);
        rp = '{1'b0, 1'b1, 1'b0, 1'b1, {10'h155, i}, 16'h0, 1'b1};
        tick(2);
        `CHK(r_dq, {`SEMH_DATA_W{f}})
        rp = r_idle;
        tick(2);
    endtask : r_rd

    task automatic t_init;
        wait_done(200);
        tick(1);
        `CHK(req_ready_o, 1'b1)
        r_rd(3'h0, 1'b0);
        r_rd(3'h7, 1'b0);
        for (int i = 0; i < 8; i++)
            r_wr(3'(i), 1'b1);
        r_rd(3'h7, 1'b1);
        $display("test init done");
    endtask : t_init

    task automatic t_lock;
        do_op(OP_TRY, 3'h2, 100);
        `CHK(rsp_o, 17'h10000)
        r_rd(3'h2, 1'b1);
        r_wr(3'h2, 1'b0);
        r_rd(3'h2, 1'b1);
        do_op(OP_PEEK, 3'h2, 100);
        `CHK(rsp_o, 17'h10000)
        do_op(OP_REL, 3'h2, 100);
        `CHK(c, wr_cyc)
        `CHK(rsp_o, 17'h10000)
        r_rd(3'h2, 1'b0);
        do_op(OP_PEEK, 3'h2, 100);
        `CHK(rsp_o, 17'h0ffff)
        r_wr(3'h2, 1'b1);
        r_rd(3'h2, 1'b1);
        $display("test lock done");
    endtask : t_lock

    task automatic t_pend;
        r_wr(3'h7, 1'b0);
        do_op(OP_TRY, 3'h7, 100);
        `CHK(rsp_o, 17'h0ffff)
        r_wr(3'h7, 1'b1);
        r_rd(3'h7, 1'b1);
        do_op(OP_PEEK, 3'h7, 100);
        `CHK(rsp_o, 17'h10000)
        do_op(OP_REL, 3'h7, 100);
        r_wr(3'h7, 1'b0);
        r_rd(3'h7, 1'b0);
        r_wr(3'h7, 1'b1);
        $display("test pend done");
    endtask : t_pend

    task automatic t_wait;
        r_wr(3'h5, 1'b0);
        fork
            do_op(OP_WAIT, 3'h5, 3000);
            begin
                tick(200);
                r_wr(3'h5, 1'b1);
            end
        join
        `CHK(rsp_o, 17'h10000)
        `CHK(c > 150, 1'b1)
        do_op(OP_REL, 3'h5, 100);
        r_rd(3'h5, 1'b1);
        $display("test wait done");
    endtask : t_wait

    // requested sweep, an unknown code, then a reset while the controller is idle
    task automatic t_misc;
        do_op(OP_TRY, 3'h3, 100);
        `CHK(rsp_o, 17'h10000)
        r_wr(3'h3, 1'b0);
        do_op(OP_INIT, 3'h5, 200);
        `CHK(c, 8 * wr_cyc)
        `CHK(rsp_o, 17'h10000)
        r_rd(3'h3, 1'b0);
        r_wr(3'h3, 1'b1);
        req_i = '{semh_op_t'(3'h5), 3'h1};
        req_valid_i = 1'b1;
        tick(1);
        req_valid_i = 1'b0;
        tick(20);
        `CHK(req_ready_o, 1'b1)
        `CHK(pins_o.sem_n, 1'b1)
        rstn_i = 1'b0;
        tick(2);
        `CHK(req_ready_o, 1'b0)
        `CHK(pins_o.sem_n, 1'b1)
        `CHK(rsp_o, 17'h00000)
        rstn_i = 1'b1;
        wait_done(200);
        `CHK(c, 8 * wr_cyc)
        tick(1);
        `CHK(req_ready_o, 1'b1)
        $display("test misc done");
    endtask : t_misc

    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        mclk_i = 1'b0;
        rstn_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        rp = r_idle;
        tick(20);
        rstn_i = 1'b1;
        t_init();
        t_lock();
        t_pend();
        t_wait();
        t_misc();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        complete_run();
    end
endmodule : tb_semh_ctrl
